// *** hw/rcia_pkg.sv ***
// constants, register map and types for the radio control input actions block
package rcia_pkg;
  localparam int NUM_LINES = 11;
  localparam int CODE_W    = 5;
  localparam int CH_W      = 5;
  localparam int DEB_W     = 7;
  // line indices inside the internal line vector
  localparam int LN_BLOCK  = 0;
  localparam int LN_SUPP_A = 1;
  localparam int LN_SUPP_B = 2;
  localparam int LN_DOWN   = 3;
  localparam int LN_UP     = 4;
  localparam int LN_HOME   = 5;
  localparam int LN_CODE0  = 6;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_POL      = 8'h04;
  localparam logic [7:0] OFF_CODE_CNT = 8'h08;
  localparam logic [7:0] OFF_LAST_CH  = 8'h0c;
  localparam logic [7:0] OFF_HOME     = 8'h10;
  localparam logic [7:0] OFF_CHAN     = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_DEB_BASE = 8'h40;
  localparam logic [7:0] DEB_IDX_MASK = 8'h3c;
  localparam int         DEB_IDX_LSB  = 2;
  localparam int         DEB_IDX_W    = 4;
  // field positions
  localparam int CTRL_BIN     = 0;
  localparam int CTRL_WRAP    = 1;
  localparam int ST_ARMED_LSB = 11;
  localparam int ST_GRANT     = 22;
  localparam int ST_KEY       = 23;
  localparam int ST_RF        = 24;
  localparam int ST_PEND      = 25;
  // reset values, limits and decode constants
  localparam logic [1:0]           CTRL_RST     = 2'h0;
  localparam logic [NUM_LINES-1:0] POL_RST      = 11'h7ff;
  localparam logic [2:0]           CODE_CNT_RST = 3'h5;
  localparam logic [2:0]           CODE_CNT_MAX = 3'h5;
  localparam logic [CH_W-1:0]      LAST_CH_RST  = 5'h10;
  localparam logic [CH_W-1:0]      HOME_RST     = 5'h01;
  localparam logic [CH_W-1:0]      CH_FIRST     = 5'h01;
  localparam logic [DEB_W-1:0]     DEB_RST      = 7'h0a;
  localparam logic [DEB_W-1:0]     DEB_MAX      = 7'h64;
  localparam logic [3:0]           BCD_UNIT_MAX = 4'h9;
  localparam logic [CH_W-1:0]      BCD_TENS     = 5'h0a;
  // timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int WIN_US     = 300;
  localparam int SETTLE_MS  = 4;
  localparam int MS_CYCLES  = CLK_HZ / 1000;
  localparam int WIN_CYCLES = (WIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam logic [2:0] SETTLE_CNT = 3'(SETTLE_MS);
  typedef enum logic [1:0] {TX_IDLE, TX_WINDOW, TX_GRANT, TX_LOCKOUT} rcia_tx_t;
endpackage

// *** hw/rcia_input_actions.sv ***
// debounced programmable control inputs steering transmit and channel selection
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rcia_input_actions #(
  parameter int MS_CYCLES  = rcia_pkg::MS_CYCLES,
  parameter int WIN_CYCLES = rcia_pkg::WIN_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        transmit_request_block,
  input  wire logic        carrier_suppress_a,
  input  wire logic        carrier_suppress_b,
  input  wire logic        chan_down_in,
  input  wire logic        chan_up_in,
  input  wire logic        home_chan_in,
  input  wire logic [4:0]  channel_code_lines,
  input  wire logic        ptt_req,
  input  wire logic        other_tx_req,
  input  wire logic        emerg_tx,
  output logic             ptt_grant,
  output logic             tx_key,
  output logic             rf_enable,
  output logic      [4:0]  chan
);
  localparam int N    = rcia_pkg::NUM_LINES;
  localparam int CW   = rcia_pkg::CODE_W;
  localparam int HW   = rcia_pkg::CH_W;
  localparam int DW   = rcia_pkg::DEB_W;
  localparam int MSW  = $clog2(MS_CYCLES + 1);
  localparam int WW   = $clog2(WIN_CYCLES + 1);
  localparam logic [MSW-1:0] MS_LAST  = MSW'(MS_CYCLES - 1);
  localparam logic [WW-1:0]  WIN_LAST = WW'(WIN_CYCLES - 1);

  function automatic logic [HW-1:0] dec_code(input logic [CW-1:0] c, input logic binary_decode_mode);
    logic [HW-1:0] r;
    r = c;
    if (!binary_decode_mode) begin
      if (c[3:0] > rcia_pkg::BCD_UNIT_MAX) begin
        r = '0;
      end else if (c[CW-1]) begin
        r = HW'(c[3:0]) + rcia_pkg::BCD_TENS;
      end else begin
        r = HW'(c[3:0]);
      end
    end
    return r;
  endfunction
  logic [1:0]        ctrl_ff;
  logic [N-1:0]      pol_ff;
  logic [2:0]        code_cnt_ff;
  logic [HW-1:0]     last_ch_ff;
  logic [HW-1:0]     home_ff;
  logic [DW-1:0]     deb_ff [N];
  logic              wait_ff;
  logic [31:0]       rdata_ff;
  logic [MSW-1:0]    ms_cnt_ff;
  logic              ms_tick_ff;
  logic [N-1:0]      raw;
  logic [N-1:0]      lvl;
  logic [N-1:0]      filt;
  logic [N-1:0]      valid;
  logic [N-1:0]      armed;
  logic [N-1:0]      accept;
  logic [N-1:0]      rise;
  logic [N-1:0]      act;
  logic [CW-1:0]     code_seen_ff;
  logic [2:0]        settle_cnt_ff;
  logic              settled_ff;
  logic              code_evt_ff;
  logic              pend_ff;
  logic [HW-1:0]     pend_ch_ff;
  logic [HW-1:0]     chan_ff;
  rcia_pkg::rcia_tx_t state_ff;
  rcia_pkg::rcia_tx_t nxt_state;
  logic [WW-1:0]     win_cnt_ff;
  logic              ptt_prev_ff;
  logic              supp_prev_ff;
  logic              ptt_grant_ff;
  logic              tx_key_ff;
  logic              rf_enable_ff;
  assign raw = {channel_code_lines, home_chan_in, chan_up_in, chan_down_in,
                carrier_suppress_b, carrier_suppress_a, transmit_request_block};
  assign lvl = ~(raw ^ pol_ff);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_ff  <= '0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == MS_LAST);
      ms_cnt_ff  <= (ms_cnt_ff == MS_LAST) ? '0 : ms_cnt_ff + 1'b1;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      logic [DW-1:0] cnt_ff;
      logic          f_ff;
      logic          v_ff;
      logic          a_ff;
      wire           mism = (lvl[gi] != f_ff) || !v_ff;
      wire           acc  = mism && (cnt_ff >= deb_ff[gi]);
      assign accept[gi] = acc;
      assign filt[gi]   = f_ff;
      assign valid[gi]  = v_ff;
      assign armed[gi]  = a_ff;
      assign rise[gi]   = acc && lvl[gi] && a_ff;
      assign act[gi]    = f_ff && a_ff;
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_ff <= '0;
          f_ff   <= 1'b0;
          v_ff   <= 1'b0;
          a_ff   <= 1'b0;
        end else begin
          if (!mism || acc) begin
            cnt_ff <= '0;
          end else if (ms_tick_ff) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
          if (acc) begin
            f_ff <= lvl[gi];
            v_ff <= 1'b1;
          end
          a_ff <= a_ff || (acc && !lvl[gi]);
        end
      end
    end
  endgenerate

  // code lines
  wire [CW-1:0] code_mask;
  wire [CW-1:0] code_now;
  wire          code_ok = &valid[N-1:rcia_pkg::LN_CODE0];
  generate
    for (gi = 0; gi < CW; gi++) begin : g_mask
      assign code_mask[gi] = (3'(gi) < code_cnt_ff);
    end
  endgenerate
  assign code_now = filt[N-1:rcia_pkg::LN_CODE0] & code_mask;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_seen_ff  <= '0;
      settle_cnt_ff <= '0;
      settled_ff    <= 1'b0;
      code_evt_ff   <= 1'b0;
    end else begin
      code_evt_ff <= 1'b0;
      if (code_now != code_seen_ff) begin
        code_seen_ff  <= code_now;
        settle_cnt_ff <= '0;
        settled_ff    <= 1'b0;
      end else if (code_ok && !settled_ff && ms_tick_ff) begin
        if (settle_cnt_ff == rcia_pkg::SETTLE_CNT) begin
          settled_ff  <= 1'b1;
          code_evt_ff <= 1'b1;
        end else begin
          settle_cnt_ff <= settle_cnt_ff + 1'b1;
        end
      end
    end
  end

  // channel selection
  wire [HW-1:0] code_ch    = dec_code(code_seen_ff, ctrl_ff[rcia_pkg::CTRL_BIN]);
  wire          code_chok  = (code_ch != '0) && (code_ch <= last_ch_ff);
  wire          code_take  = code_evt_ff && code_chok;
  wire          pend_apply = pend_ff && !tx_key_ff;
  wire          wrap       = ctrl_ff[rcia_pkg::CTRL_WRAP];
  wire          home_evt   = rise[rcia_pkg::LN_HOME];
  wire          up_evt     = rise[rcia_pkg::LN_UP];
  wire          down_evt   = rise[rcia_pkg::LN_DOWN];
  wire [HW-1:0] up_ch   = (chan_ff >= last_ch_ff) ? (wrap ? rcia_pkg::CH_FIRST : chan_ff)
                                                  : chan_ff + 1'b1;
  wire [HW-1:0] down_ch = (chan_ff <= rcia_pkg::CH_FIRST) ? (wrap ? last_ch_ff : chan_ff)
                                                          : chan_ff - 1'b1;
  wire [HW-1:0] nxt_chan = home_evt                  ? home_ff :
                           (code_take && !tx_key_ff) ? code_ch :
                           pend_apply                ? pend_ch_ff :
                           up_evt                    ? up_ch :
                           down_evt                  ? down_ch : chan_ff;
  wire          nxt_pend = (code_take && tx_key_ff) || (pend_ff && !pend_apply);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_ff    <= rcia_pkg::CH_FIRST;
      pend_ff    <= 1'b0;
      pend_ch_ff <= rcia_pkg::CH_FIRST;
    end else begin
      chan_ff <= nxt_chan;
      pend_ff <= nxt_pend;
      if (code_take && tx_key_ff) begin
        pend_ch_ff <= code_ch;
      end
    end
  end

  // transmit control
  wire blk_eff   = act[rcia_pkg::LN_BLOCK] && !emerg_tx;
  wire supp_eff  = (act[rcia_pkg::LN_SUPP_A] || act[rcia_pkg::LN_SUPP_B])
                   && !emerg_tx;
  wire supp_rise = supp_eff && !supp_prev_ff;
  wire ptt_rise  = ptt_req && !ptt_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rcia_pkg::TX_IDLE: begin
        if (ptt_rise) begin
          nxt_state = blk_eff ? rcia_pkg::TX_LOCKOUT : rcia_pkg::TX_WINDOW;
        end
      end
      rcia_pkg::TX_WINDOW: begin
        if (!ptt_req) begin
          nxt_state = rcia_pkg::TX_IDLE;
        end else if (blk_eff || supp_rise) begin
          nxt_state = rcia_pkg::TX_LOCKOUT;
        end else if (win_cnt_ff == WIN_LAST) begin
          nxt_state = rcia_pkg::TX_GRANT;
        end
      end
      rcia_pkg::TX_GRANT: begin
        if (!ptt_req) begin
          nxt_state = rcia_pkg::TX_IDLE;
        end else if (blk_eff) begin
          nxt_state = rcia_pkg::TX_LOCKOUT;
        end
      end
      rcia_pkg::TX_LOCKOUT: begin
        if (!ptt_req) begin
          nxt_state = rcia_pkg::TX_IDLE;
        end
      end
      default: nxt_state = rcia_pkg::TX_IDLE;
    endcase
  end

  wire nxt_grant = (nxt_state == rcia_pkg::TX_GRANT);
  wire nxt_key   = nxt_grant || other_tx_req || emerg_tx;
  wire nxt_rf    = nxt_key && !supp_eff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= rcia_pkg::TX_IDLE;
      win_cnt_ff   <= '0;
      ptt_prev_ff  <= 1'b0;
      supp_prev_ff <= 1'b0;
      ptt_grant_ff <= 1'b0;
      tx_key_ff    <= 1'b0;
      rf_enable_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      win_cnt_ff   <= (state_ff == rcia_pkg::TX_WINDOW) ? win_cnt_ff + 1'b1 : '0;
      ptt_prev_ff  <= ptt_req;
      supp_prev_ff <= supp_eff;
      ptt_grant_ff <= nxt_grant;
      tx_key_ff    <= nxt_key;
      rf_enable_ff <= nxt_rf;
    end
  end

  // register bus
  localparam int DEB_IDX_W = rcia_pkg::DEB_IDX_W;
  wire                 req     = avs_read || avs_write;
  wire                 do_wr   = avs_write && !wait_ff;
  wire [DEB_IDX_W-1:0] deb_idx = avs_address[rcia_pkg::DEB_IDX_LSB +: DEB_IDX_W];
  wire deb_hit = ((avs_address & ~rcia_pkg::DEB_IDX_MASK) == rcia_pkg::OFF_DEB_BASE)
                 && (deb_idx < DEB_IDX_W'(N));
  wire [31:0] status = {6'h00, pend_ff, rf_enable_ff, tx_key_ff, ptt_grant_ff,
                        armed, filt};
  wire [31:0] rd_mux =
    (avs_address == rcia_pkg::OFF_CTRL)     ? 32'(ctrl_ff) :
    (avs_address == rcia_pkg::OFF_POL)      ? 32'(pol_ff) :
    (avs_address == rcia_pkg::OFF_CODE_CNT) ? 32'(code_cnt_ff) :
    (avs_address == rcia_pkg::OFF_LAST_CH)  ? 32'(last_ch_ff) :
    (avs_address == rcia_pkg::OFF_HOME)     ? 32'(home_ff) :
    (avs_address == rcia_pkg::OFF_CHAN)     ? 32'(chan_ff) :
    (avs_address == rcia_pkg::OFF_STATUS)   ? status :
    deb_hit                                 ? 32'(deb_ff[deb_idx]) : 32'h0000_0000;
  wire [DW-1:0] wr_deb = (avs_writedata > 32'(rcia_pkg::DEB_MAX)) ? rcia_pkg::DEB_MAX
                                                                  : avs_writedata[DW-1:0];
  wire [2:0] wr_cnt = (avs_writedata > 32'(rcia_pkg::CODE_CNT_MAX)) ? rcia_pkg::CODE_CNT_MAX
                                                                   : avs_writedata[2:0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff     <= 1'b1;
      rdata_ff    <= '0;
      ctrl_ff     <= rcia_pkg::CTRL_RST;
      pol_ff      <= rcia_pkg::POL_RST;
      code_cnt_ff <= rcia_pkg::CODE_CNT_RST;
      last_ch_ff  <= rcia_pkg::LAST_CH_RST;
      home_ff     <= rcia_pkg::HOME_RST;
      for (int i = 0; i < N; i++) begin
        deb_ff[i] <= rcia_pkg::DEB_RST;
      end
    end else begin
      wait_ff <= !(wait_ff && req);
      if (wait_ff && req) begin
        rdata_ff <= avs_read ? rd_mux : 32'h0000_0000;
      end
      if (do_wr) begin
        case (avs_address)
          rcia_pkg::OFF_CTRL:     ctrl_ff     <= avs_writedata[1:0];
          rcia_pkg::OFF_POL:      pol_ff      <= avs_writedata[N-1:0];
          rcia_pkg::OFF_CODE_CNT: code_cnt_ff <= wr_cnt;
          rcia_pkg::OFF_LAST_CH:  last_ch_ff  <= avs_writedata[HW-1:0];
          rcia_pkg::OFF_HOME:     home_ff     <= avs_writedata[HW-1:0];
          default: begin
            if (deb_hit) begin
              deb_ff[deb_idx] <= wr_deb;
            end
          end
        endcase
      end
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign ptt_grant       = ptt_grant_ff;
  assign tx_key          = tx_key_ff;
  assign rf_enable       = rf_enable_ff;
  assign chan            = chan_ff;
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_press_clear;
    state_ff == rcia_pkg::TX_IDLE && ptt_rise && !blk_eff;
  endsequence
  sequence s_no_grant;
    !ptt_grant_ff [*8];
  endsequence

  a_block_ends_ptt: assert property (blk_eff |=> !ptt_grant_ff)
    else $error("push-to-talk grant survived the transmit block");
  a_window_delays: assert property (s_press_clear |=> s_no_grant)
    else $error("push-to-talk granted inside the guard window");
  a_window_abort: assert property (state_ff == rcia_pkg::TX_WINDOW && ptt_req && supp_rise
                                   |=> state_ff == rcia_pkg::TX_LOCKOUT)
    else $error("suppress inside the window did not cancel the press");
  a_other_tx_keys: assert property (other_tx_req |=> tx_key_ff)
    else $error("non push-to-talk transmission did not key");
  a_emerg_rf_on: assert property (emerg_tx |=> tx_key_ff && rf_enable_ff)
    else $error("emergency transmission was suppressed");
  a_supp_cuts_rf: assert property (supp_eff |=> !rf_enable_ff)
    else $error("rf stayed on under suppress");
  a_supp_or_b: assert property (act[rcia_pkg::LN_SUPP_B] && !emerg_tx |=> !rf_enable_ff)
    else $error("second suppress line ignored");
  a_supp_fast: assert property (lvl[rcia_pkg::LN_SUPP_A] != filt[rcia_pkg::LN_SUPP_A]
                                && deb_ff[rcia_pkg::LN_SUPP_A] == '0
                                |=> filt[rcia_pkg::LN_SUPP_A] == $past(lvl[rcia_pkg::LN_SUPP_A]))
    else $error("suppress line response too slow");
  a_rf_restore: assert property (tx_key_ff && $fell(supp_eff) ##0 nxt_key
                                 |=> rf_enable_ff)
    else $error("rf not restored after suppress release");
  a_key_drops: assert property (!nxt_key |=> !tx_key_ff && !rf_enable_ff)
    else $error("transmit key held after sources ended");
  a_down_floor: assert property (down_evt && !up_evt && !home_evt && !code_evt_ff && !pend_ff
                                 && chan_ff == rcia_pkg::CH_FIRST && !wrap
                                 |=> $stable(chan_ff))
    else $error("channel down moved below the first channel");
  a_code_defer: assert property (code_take && tx_key_ff && !home_evt && !up_evt && !down_evt
                                 |=> pend_ff && $stable(chan_ff))
    else $error("code change applied while transmitting");
endmodule // rcia_input_actions

// *** tb/rcia_ctl_model.sv ***
// driver model for the control lines of the input actions block
`timescale 1ns/1ps
module rcia_ctl_model #(
  parameter int MS     = 20,
  parameter int DEB_MS = 10
) (
  input  wire logic       core_clk,
  output logic            blk,
  output logic            sup_a,
  output logic            sup_b,
  output logic            dn,
  output logic            up,
  output logic            home,
  output logic      [4:0] code
);
  logic [10:0] lines_ff;

  assign {code, home, up, dn, sup_b, sup_a, blk} = lines_ff;

  initial lines_ff = 11'h000;

  task automatic set(input int i, input logic v);
    @(posedge core_clk);
    lines_ff[i] <= v;
  endtask

  task automatic set_code(input logic [4:0] v);
    @(posedge core_clk);
    lines_ff[10:6] <= v;
  endtask

  // held for debounce plus 2 ms, then 20 ms quiet, which also covers the wait after home
  task automatic pulse(input int i);
    set(i, 1'b1);
    repeat ((DEB_MS + 2) * MS) @(posedge core_clk);
    set(i, 1'b0);
    repeat (20 * MS) @(posedge core_clk);
  endtask
endmodule // rcia_ctl_model

// *** tb/tb_top.sv ***
// self-checking testbench for the input actions block
`timescale 1ns/1ps
module tb_top;
  localparam int MS  = 20;
  localparam int WIN = 12;
  logic        core_clk      = 1'b0;
  logic        arst_n        = 1'b0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        ptt_req       = 1'b0;
  logic        other_tx_req  = 1'b0;
  logic        emerg_tx      = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ptt_grant;
  logic        tx_key;
  logic        rf_enable;
  logic [4:0]  chan;
  logic        blk, sup_a, sup_b, dn, up, home;
  logic [4:0]  code;
  logic [31:0] rd;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40, 8'h30};
  logic [31:0] rv [8] = '{32'h0, 32'h7ff, 32'h5, 32'h10, 32'h1, 32'h1, 32'h0a, 32'h0};
  logic [4:0]  cv [6] = '{5'h03, 5'h0a, 5'h12, 5'h11, 5'h00, 5'h1f};
  logic [4:0]  ce [6] = '{5'h03, 5'h03, 5'h0c, 5'h11, 5'h11, 5'h07};
  int          si [7] = '{5, 4, 3, 5, 3, 3, 4};
  logic [4:0]  se [7] = '{5'h05, 5'h06, 5'h05, 5'h01, 5'h01, 5'h1f, 5'h01};

  always #5 core_clk = ~core_clk;

  rcia_ctl_model #(.MS(MS), .DEB_MS(10)) m (
    .core_clk(core_clk), .blk(blk), .sup_a(sup_a), .sup_b(sup_b),
    .dn(dn), .up(up), .home(home), .code(code));

  rcia_input_actions #(.MS_CYCLES(MS), .WIN_CYCLES(WIN)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .transmit_request_block(blk), .carrier_suppress_a(sup_a),
    .carrier_suppress_b(sup_b), .chan_down_in(dn), .chan_up_in(up),
    .home_chan_in(home), .channel_code_lines(code), .ptt_req(ptt_req),
    .other_tx_req(other_tx_req), .emerg_tx(emerg_tx), .ptt_grant(ptt_grant),
    .tx_key(tx_key), .rf_enable(rf_enable), .chan(chan));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic txc(input logic [2:0] e);
    chk("grant_key_rf", 32'({ptt_grant, tx_key, rf_enable}), 32'(e));
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    wt(300);
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, ra[i], 32'h0);
      chk("register", rd, rv[i]);
    end
    acc(1'b1, 8'h40, 32'hff);
    acc(1'b0, 8'h40, 32'h0);
    chk("debounce", rd, 32'h64);
    for (int i = 0; i < 3; i++) acc(1'b1, 8'h40 + 8'(4 * i), 32'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      if (i == 3) acc(1'b1, 8'h00, 32'h1);
      if (i == 3) acc(1'b1, 8'h0c, 32'h1f);
      if (i == 5) acc(1'b1, 8'h08, 32'h3);
      m.set_code(cv[i]);
      wt(400);
      chk("chan", 32'(chan), 32'(ce[i]));
    end
    $display("test code lines done");
    acc(1'b1, 8'h10, 32'h5);
    for (int i = 0; i < 7; i++) begin
      if (i == 3) acc(1'b1, 8'h10, 32'h1);
      if (i == 5) acc(1'b1, 8'h00, 32'h3);
      m.pulse(si[i]);
      chk("chan", 32'(chan), 32'(se[i]));
    end
    $display("test steps done");
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(WIN + 5);
    txc(3'b111);
    m.set(1, 1'b1);
    wt(50);
    txc(3'b110);
    m.set(2, 1'b1);
    m.set(1, 1'b0);
    wt(50);
    txc(3'b110);
    m.set(2, 1'b0);
    wt(50);
    txc(3'b111);
    m.set(0, 1'b1);
    wt(50);
    txc(3'b000);
    @(posedge core_clk) ptt_req <= 1'b0;
    wt(3);
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(30);
    txc(3'b000);
    @(posedge core_clk) ptt_req <= 1'b0;
    other_tx_req <= 1'b1;
    wt(5);
    txc(3'b011);
    m.set(1, 1'b1);
    @(posedge core_clk) emerg_tx <= 1'b1;
    wt(5);
    txc(3'b011);
    @(posedge core_clk) emerg_tx <= 1'b0;
    wt(5);
    txc(3'b010);
    @(posedge core_clk) other_tx_req <= 1'b0;
    m.set(0, 1'b0);
    wt(50);
    txc(3'b000);
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(WIN + 5);
    txc(3'b110);
    @(posedge core_clk) ptt_req <= 1'b0;
    wt(5);
    txc(3'b000);
    m.set(1, 1'b0);
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(3);
    m.set(1, 1'b1);
    wt(30);
    txc(3'b000);
    @(posedge core_clk) ptt_req <= 1'b0;
    m.set(1, 1'b0);
    wt(50);
    $display("test transmit done");
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(WIN + 5);
    m.set_code(5'h04);
    wt(400);
    chk("chan", 32'(chan), 32'h1);
    @(posedge core_clk) ptt_req <= 1'b0;
    wt(10);
    chk("chan", 32'(chan), 32'h4);
    $display("test deferred code done");
    @(posedge core_clk) other_tx_req <= 1'b1;
    acc(1'b1, 8'h04, 32'h7fd);
    wt(50);
    txc(3'b010);
    acc(1'b1, 8'h04, 32'h7ff);
    wt(50);
    txc(3'b011);
    @(posedge core_clk) other_tx_req <= 1'b0;
    wt(5);
    $display("test polarity done");
    m.set(0, 1'b1);
    @(posedge core_clk) arst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    wt(400);
    acc(1'b0, 8'h18, 32'h0);
    chk("status", rd, 32'h0037_f101);
    chk("chan", 32'(chan), 32'h4);
    @(posedge core_clk) ptt_req <= 1'b1;
    wt(WIN + 5);
    txc(3'b111);
    m.set(0, 1'b0);
    wt(250);
    m.set(0, 1'b1);
    wt(250);
    txc(3'b000);
    @(posedge core_clk) ptt_req <= 1'b0;
    wt(5);
    $display("test power-up done");
    end_of_test();
  end
endmodule // tb_top
